// ===== hdl/dram_cke_and_command_decode.sv
// Command-side state handling of a synchronous DRAM: clock-enable driven
// power-down and self refresh, impedance calibration, row open and read.
// Assumes the controller drives pins on this clock; pins are synchronised.
//
// Summary of operation
// - Decode commands from strobes at rising edge
// - Judge using prior state and two CKE samples
// - Low-low holds; low-high with DES/NOP exits
// - High-low DES/NOP from busy enters power-down
// - Idle (no open row, no burst) enters precharge power-down
// - REFRESH with CKE falling from idle, no calibration running: self refresh
// - Termination input never affects CKE transitions
// - DESELECT takes no command, ongoing work continues
// - NOP registers nothing, ongoing work continues
// - Long calibration starts engine, updates impedances
// - Short calibration finishes within 64 cycles
// - ACTIVATE opens addressed row in bank
// - READ starts burst at low column bits
// - Address bit 10 selects auto precharge
// - Bit 12 chooses chop when on-the-fly enabled
// - READ burst runs to completion uninterrupted
// - READ encoding with CKE high both edges
module dram_cke_and_command_decode #(
  parameter int INIT_CAL = dram_cmd_pkg::INIT_CAL_CYC,
  parameter int OPER_CAL = dram_cmd_pkg::OPER_CAL_CYC
) (
  input  wire logic                          clk_sys_in,      // 10 MHz clock
  input  wire logic                          resetn_in,       // Async reset, active low
  input  wire logic                          ce_in,           // Clock enable for all state
  input  wire logic                          cke_in,          // DRAM clock-enable pin
  input  wire dram_cmd_pkg::cmd_pins_t       pins_in,         // Command/address pins
  input  wire logic                          odt_in,          // Termination pin, unused
  input  wire logic                          otf_en_in,       // On-the-fly burst enable
  input  wire logic                          cfg_chop_in,     // Configured chop length
  input  wire logic                          init_done_in,    // Initialisation finished
  output logic [2:0]                         pstate_out,      // Power state
  output dram_cmd_pkg::read_info_t           read_out,        // Read launch, pulse
  output logic                               burst_busy_out,  // Burst in flight
  output logic                               cal_busy_out,    // Calibration running
  output logic                               imp_update_out,  // Impedance update pulse
  output logic [(1<<dram_cmd_pkg::BANK_W)-1:0] bank_open_out, // Open bank flags
  output logic                               act_out,         // ACTIVATE taken, pulse
  output logic [dram_cmd_pkg::ADDR_W-1:0]    act_row_out      // Row of last ACTIVATE
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  dram_cmd_pkg::cmd_pins_t pins_s1_ff, pins_s2_ff;
  logic cke_s1_ff, cke_s2_ff, cke_prev_ff;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pins_s1_ff  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      pins_s2_ff  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      cke_s1_ff   <= 1'b0;
      cke_s2_ff   <= 1'b0;
      cke_prev_ff <= 1'b0;
    end else if (ce_in) begin
      pins_s1_ff  <= pins_in;
      pins_s2_ff  <= pins_s1_ff;
      cke_s1_ff   <= cke_in;
      cke_s2_ff   <= cke_s1_ff;
      cke_prev_ff <= cke_s2_ff;
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  function automatic dram_cmd_pkg::cmd_t decode(input dram_cmd_pkg::cmd_pins_t p);
    logic [2:0] s;
    s = {p.ras_n, p.cas_n, p.we_n};
    if (p.cs_n) begin
      decode = dram_cmd_pkg::CMD_DESELECT;
    end else begin
      case (s)
        3'h7:    decode = dram_cmd_pkg::CMD_NOP;
        3'h3:    decode = dram_cmd_pkg::CMD_ACTIVATE;
        3'h5:    decode = dram_cmd_pkg::CMD_READ;
        3'h4:    decode = dram_cmd_pkg::CMD_WRITE;
        3'h2:    decode = dram_cmd_pkg::CMD_PRECHG;
        3'h1:    decode = dram_cmd_pkg::CMD_REFRESH;
        3'h0:    decode = dram_cmd_pkg::CMD_MODE_SET;
        default: decode = p.addr[dram_cmd_pkg::A10_POS] ?
                          dram_cmd_pkg::CMD_CAL_LONG : dram_cmd_pkg::CMD_CAL_SHRT;
      endcase
    end
  endfunction : decode

  function automatic logic [dram_cmd_pkg::CAL_CNT_W-1:0] cycles(input int n);
    cycles = dram_cmd_pkg::CAL_CNT_W'(n);
  endfunction : cycles

  // termination input deliberately not read by any logic.
  wire dram_cmd_pkg::cmd_t cmd     = decode(pins_s2_ff);
  wire logic               cke_now = cke_s2_ff;
  wire logic               quiet   = (cmd == dram_cmd_pkg::CMD_DESELECT) ||
                                     (cmd == dram_cmd_pkg::CMD_NOP);
  wire logic               fall    = cke_prev_ff && !cke_now;
  wire logic               rise    = !cke_prev_ff && cke_now;
  wire logic               run     = cke_prev_ff && cke_now;

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  dram_cmd_pkg::pstate_t state_ff, nxt_state;

  wire logic asleep   = (state_ff == dram_cmd_pkg::ST_ACT_PDOWN) ||
                        (state_ff == dram_cmd_pkg::ST_PRE_PDOWN) ||
                        (state_ff == dram_cmd_pkg::ST_SELF_REF);
  wire logic any_open = |bank_open_out;
  wire logic busy     = any_open || burst_busy_out;
  wire logic take     = !asleep && run;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dram_cmd_pkg::ST_IDLE, dram_cmd_pkg::ST_ACTIVE: begin
        if (fall && quiet) begin
          nxt_state = busy ? dram_cmd_pkg::ST_ACT_PDOWN
                           : dram_cmd_pkg::ST_PRE_PDOWN;
        end else if (fall && cmd == dram_cmd_pkg::CMD_REFRESH && !busy && !cal_busy_out) begin
          nxt_state = dram_cmd_pkg::ST_SELF_REF;
        end else begin
          nxt_state = any_open ? dram_cmd_pkg::ST_ACTIVE : dram_cmd_pkg::ST_IDLE;
        end
      end
      dram_cmd_pkg::ST_ACT_PDOWN, dram_cmd_pkg::ST_PRE_PDOWN: begin
        if (rise && quiet) begin
          nxt_state = any_open ? dram_cmd_pkg::ST_ACTIVE : dram_cmd_pkg::ST_IDLE;
        end
      end
      dram_cmd_pkg::ST_SELF_REF: begin
        if (rise && quiet) begin
          nxt_state = dram_cmd_pkg::ST_IDLE;
        end
      end
      default: nxt_state = dram_cmd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= dram_cmd_pkg::ST_IDLE;
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end
  assign pstate_out = state_ff;

  // ****************************************************************
  // Row table
  // ****************************************************************
  wire logic do_act  = take && cmd == dram_cmd_pkg::CMD_ACTIVATE;
  wire logic do_pre  = take && cmd == dram_cmd_pkg::CMD_PRECHG;
  wire logic do_read = take && cmd == dram_cmd_pkg::CMD_READ &&
                       !burst_busy_out && bank_open_out[pins_s2_ff.bank];
  logic                        ap_pend_ff;
  logic [dram_cmd_pkg::BANK_W-1:0] ap_bank_ff;
  logic                        burst_end;
  // A finished auto precharge waits while ACTIVATE or PRECHARGE holds the
  // single row-table write port, so neither close is lost
  wire logic close_ap = ap_pend_ff && (burst_end || !burst_busy_out) &&
                        !do_act && !do_pre;
  wire logic [dram_cmd_pkg::BANK_W-1:0] close_bank = close_ap ? ap_bank_ff : pins_s2_ff.bank;

  row_table #(
    .BANK_W (dram_cmd_pkg::BANK_W),
    .ROW_W  (dram_cmd_pkg::ADDR_W)
  ) u_rows (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .ce_in      (ce_in),
    .open_in    (do_act),
    .close_in   (do_pre || close_ap),
    .wbank_in   (do_act ? pins_s2_ff.bank : close_bank),
    .wrow_in    (pins_s2_ff.addr),
    .rbank_in   (pins_s2_ff.bank),
    .rrow_out   (),
    .open_out   (bank_open_out)
  );

  // ****************************************************************
  // Read burst
  // ****************************************************************
  logic [dram_cmd_pkg::BEAT_CNT_W-1:0] beats_ff;
  wire logic chop_sel = otf_en_in ? !pins_s2_ff.addr[dram_cmd_pkg::A12_POS]
                                  : cfg_chop_in;
  assign burst_end = burst_busy_out && beats_ff == dram_cmd_pkg::BEAT_CNT_W'(1);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      beats_ff       <= '0;
      burst_busy_out <= 1'b0;
      ap_pend_ff     <= 1'b0;
      ap_bank_ff     <= '0;
      read_out       <= '0;
      act_out        <= 1'b0;
      act_row_out    <= '0;
    end else if (ce_in) begin
      read_out.valid <= do_read;
      act_out        <= do_act;
      if (do_act) begin
        act_row_out <= pins_s2_ff.addr;
      end
      if (do_read) begin
        read_out.autoprecharge <= pins_s2_ff.addr[dram_cmd_pkg::A10_POS];
        read_out.chop          <= chop_sel;
        read_out.bank          <= pins_s2_ff.bank;
        read_out.start_col     <= pins_s2_ff.addr[dram_cmd_pkg::COL_W-1:0];
        ap_pend_ff             <= pins_s2_ff.addr[dram_cmd_pkg::A10_POS];
        ap_bank_ff             <= pins_s2_ff.bank;
        burst_busy_out         <= 1'b1;
        beats_ff <= chop_sel ? dram_cmd_pkg::BEAT_CNT_W'(dram_cmd_pkg::BURST_4_BEATS)
                             : dram_cmd_pkg::BEAT_CNT_W'(dram_cmd_pkg::BURST_8_BEATS);
      end else if (burst_end) begin
        burst_busy_out <= 1'b0;
        beats_ff       <= '0;
      end else if (burst_busy_out) begin
        beats_ff <= beats_ff - dram_cmd_pkg::BEAT_CNT_W'(1);
      end
      if (close_ap && !do_read) begin
        ap_pend_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Impedance calibration engine
  // ****************************************************************
  logic [dram_cmd_pkg::CAL_CNT_W-1:0] cal_cnt_ff;
  wire logic cal_long  = take && cmd == dram_cmd_pkg::CMD_CAL_LONG;
  wire logic cal_short = take && cmd == dram_cmd_pkg::CMD_CAL_SHRT;
  // Long window depends on whether initialisation is done; the short
  // window is fixed so the correction always lands inside 64 cycles.
  wire logic [dram_cmd_pkg::CAL_CNT_W-1:0] cal_len =
    cal_long ? (init_done_in ? cycles(OPER_CAL) : cycles(INIT_CAL))
             : cycles(dram_cmd_pkg::SHORT_CAL_CYC);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cal_cnt_ff     <= '0;
      cal_busy_out   <= 1'b0;
      imp_update_out <= 1'b0;
    end else if (ce_in) begin
      imp_update_out <= 1'b0;
      if ((cal_long || cal_short) && !cal_busy_out) begin
        cal_busy_out <= 1'b1;
        cal_cnt_ff   <= cal_len;
      end else if (cal_busy_out && cal_cnt_ff == cycles(1)) begin
        cal_busy_out   <= 1'b0;
        imp_update_out <= 1'b1;
        cal_cnt_ff     <= '0;
      end else if (cal_busy_out) begin
        cal_cnt_ff <= cal_cnt_ff - cycles(1);
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in || !ce_in);

  logic [6:0] short_age_ff;   // Cycles since a short calibration started
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      short_age_ff <= '0;
    end else if (ce_in) begin
      if (cal_short && !cal_busy_out) begin
        short_age_ff <= 7'h01;
      end else if (short_age_ff != 7'h00 && cal_busy_out) begin
        short_age_ff <= short_age_ff + 7'h01;
      end else begin
        short_age_ff <= '0;
      end
    end
  end

  a_pd_hold: assert property (
    asleep && !cke_prev_ff && !cke_now |=> state_ff == $past(state_ff))
    else $error("power-down state left while CKE low");
  a_sr_entry: assert property (
    state_ff == dram_cmd_pkg::ST_IDLE && fall && cmd == dram_cmd_pkg::CMD_REFRESH
    && !busy && !cal_busy_out |=> state_ff == dram_cmd_pkg::ST_SELF_REF)
    else $error("self refresh not entered");
  a_act_pd: assert property (
    !asleep && any_open && fall && quiet |=> state_ff == dram_cmd_pkg::ST_ACT_PDOWN)
    else $error("active power-down not entered");
  a_pre_pd: assert property (
    !asleep && !busy && fall && quiet |=> state_ff == dram_cmd_pkg::ST_PRE_PDOWN)
    else $error("precharge power-down not entered");
  a_sleep_ignore: assert property (
    asleep |-> !do_read && !do_act && !cal_long && !cal_short)
    else $error("command taken while asleep");
  a_quiet_keep: assert property (
    burst_busy_out && quiet && !burst_end |=> burst_busy_out)
    else $error("NOP or deselect disturbed burst");
  a_short_cal: assert property (
    cal_short && !cal_busy_out |=> cal_busy_out ##64 !cal_busy_out && imp_update_out)
    else $error("short calibration not done in 64 cycles");
  a_read_len: assert property (
    do_read && !chop_sel |=> burst_busy_out [*8] ##1 !burst_busy_out)
    else $error("eight-beat burst length wrong");
  a_read_out: assert property (
    do_read |=> read_out.valid && read_out.start_col == $past(pins_s2_ff.addr[2:0]))
    else $error("read start column wrong");
  a_short_hold: assert property (
    short_age_ff != 7'h00 && short_age_ff <= 7'(dram_cmd_pkg::SHORT_CAL_CYC) |-> cal_busy_out)
    else $error("short calibration ended early");
  a_read_chop: assert property (
    do_read && chop_sel |=> burst_busy_out [*4] ##1 !burst_busy_out)
    else $error("chopped burst length wrong");
  a_read_info: assert property (
    do_read |=> read_out.autoprecharge == $past(pins_s2_ff.addr[dram_cmd_pkg::A10_POS]) &&
    read_out.chop == ($past(otf_en_in) ? !$past(pins_s2_ff.addr[dram_cmd_pkg::A12_POS])
                                       : $past(cfg_chop_in)))
    else $error("read precharge or chop flag wrong");
  a_act_open: assert property (
    do_act |=> act_out && bank_open_out[$past(pins_s2_ff.bank)] &&
    act_row_out == $past(pins_s2_ff.addr))
    else $error("activated row not open");
  a_ap_close: assert property (
    close_ap |=> !bank_open_out[$past(ap_bank_ff)])
    else $error("auto precharge left bank open");
  a_ap_keep: assert property (
    burst_end && !ap_pend_ff && !do_pre && bank_open_out[ap_bank_ff] |=>
    bank_open_out[$past(ap_bank_ff)])
    else $error("row closed without auto precharge");
  a_pd_exit: assert property (
    (state_ff == dram_cmd_pkg::ST_ACT_PDOWN || state_ff == dram_cmd_pkg::ST_PRE_PDOWN)
    && rise && quiet |=> !asleep)
    else $error("power-down exit missed");
  a_sr_exit: assert property (
    state_ff == dram_cmd_pkg::ST_SELF_REF && rise && quiet |=>
    state_ff == dram_cmd_pkg::ST_IDLE)
    else $error("self refresh exit missed");
  a_cal_load: assert property (
    cal_long && !cal_busy_out |=> cal_busy_out &&
    cal_cnt_ff == ($past(init_done_in) ? cycles(OPER_CAL) : cycles(INIT_CAL)))
    else $error("long calibration window wrong");
  a_cal_update: assert property (
    cal_busy_out && cal_cnt_ff == cycles(1) |=> imp_update_out && !cal_busy_out)
    else $error("no impedance update at calibration end");
  a_read_refuse: assert property (
    burst_busy_out && cmd == dram_cmd_pkg::CMD_READ |=> !read_out.valid)
    else $error("read taken during burst");

  c_read:     cover property (do_read);
  c_self_ref: cover property (state_ff == dram_cmd_pkg::ST_SELF_REF ##[1:20] !asleep);
  c_cal_long: cover property (cal_long);
  c_act_pd:   cover property (state_ff == dram_cmd_pkg::ST_ACT_PDOWN);
  c_chop:     cover property (do_read && chop_sel);

endmodule : dram_cke_and_command_decode

// ===== inc/dram_cmd_pkg.sv
// Shared constants and types for the DRAM command decode block.
// Assumes a single 10 MHz clock domain; no software registers.
package dram_cmd_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int BANK_W  = 3;
  localparam int ADDR_W  = 16;
  localparam int BANKS   = 8;
  localparam int COL_W   = 3;
  localparam int A10_POS = 10;
  localparam int A12_POS = 12;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SHORT_CAL_CYC = 64;
  localparam int INIT_CAL_CYC  = 512;
  localparam int OPER_CAL_CYC  = 256;
  localparam int BURST_8_BEATS = 8;
  localparam int BURST_4_BEATS = 4;
  localparam int CAL_CNT_W     = 10;
  localparam int BEAT_CNT_W    = 4;

  // ****************************************************************
  // Command pins and decoded commands
  // ****************************************************************
  typedef struct packed {
    logic                cs_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
  } cmd_pins_t;

  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NOP      = 4'h1,
    CMD_ACTIVATE = 4'h2,
    CMD_READ     = 4'h3,
    CMD_WRITE    = 4'h4,
    CMD_PRECHG   = 4'h5,
    CMD_REFRESH  = 4'h6,
    CMD_MODE_SET = 4'h7,
    CMD_CAL_LONG = 4'h8,
    CMD_CAL_SHRT = 4'h9
  } cmd_t;

  // Gray-coded along idle -> active -> power-down paths
  typedef enum logic [2:0] {
    ST_IDLE       = 3'h0,
    ST_ACTIVE     = 3'h1,
    ST_ACT_PDOWN  = 3'h3,
    ST_PRE_PDOWN  = 3'h2,
    ST_SELF_REF   = 3'h6
  } pstate_t;

  typedef struct packed {
    logic              valid;
    logic              autoprecharge;
    logic              chop;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  start_col;
  } read_info_t;

endpackage : dram_cmd_pkg

// ===== hdl/row_table.sv
// Open-row memory: one row address and one open flag per bank.
// Assumes a single clock; read data are registered.
module row_table #(
  parameter int BANK_W = 3,
  parameter int ROW_W  = 16
) (
  input  wire logic              clk_sys_in,   // System clock
  input  wire logic              resetn_in,    // Async reset, active low
  input  wire logic              ce_in,        // Clock enable
  input  wire logic              open_in,      // Open a row
  input  wire logic              close_in,     // Close a bank
  input  wire logic [BANK_W-1:0] wbank_in,     // Bank written
  input  wire logic [ROW_W-1:0]  wrow_in,      // Row written
  input  wire logic [BANK_W-1:0] rbank_in,     // Bank read
  output logic      [ROW_W-1:0]  rrow_out,     // Registered row
  output logic      [(1<<BANK_W)-1:0] open_out // Open flags
);
  logic [ROW_W-1:0] rows_ff [(1<<BANK_W)];

  always_ff @(posedge clk_sys_in) begin
    if (ce_in && open_in) begin
      rows_ff[wbank_in] <= wrow_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      open_out <= '0;
      rrow_out <= '0;
    end else if (ce_in) begin
      rrow_out <= rows_ff[rbank_in];
      if (open_in) begin
        open_out[wbank_in] <= 1'b1;
      end else if (close_in) begin
        open_out[wbank_in] <= 1'b0;
      end
    end
  end
endmodule : row_table

// ===== bench/dram_ctrl_model.sv
// Controller-side model: drives command/address pins and clock enable.
// Assumes one bench process calls its tasks, always on clk_sys_in.
module dram_ctrl_model (
  input  wire logic               clk_sys_in, // System clock
  output dram_cmd_pkg::cmd_pins_t pins_out,   // Command/address pins
  output logic                    cke_out     // Clock enable
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int MIN_HOLD = 3;

  initial begin
    pins_out = {1'b1, 3'h7, 3'h0, 16'h0000};
    cke_out  = 1'b1;
  end

  // Strobe levels ras, cas, we; only listed encodings are ever sent
  function automatic logic [2:0] strobes(input dram_cmd_pkg::cmd_t c);
    case (c)
      dram_cmd_pkg::CMD_ACTIVATE: strobes = 3'h3;
      dram_cmd_pkg::CMD_READ:     strobes = 3'h5;
      dram_cmd_pkg::CMD_WRITE:    strobes = 3'h4;
      dram_cmd_pkg::CMD_PRECHG:   strobes = 3'h2;
      dram_cmd_pkg::CMD_REFRESH:  strobes = 3'h1;
      dram_cmd_pkg::CMD_MODE_SET: strobes = 3'h0;
      dram_cmd_pkg::CMD_CAL_LONG: strobes = 3'h6;
      dram_cmd_pkg::CMD_CAL_SHRT: strobes = 3'h6;
      default:                    strobes = 3'h7;
    endcase
  endfunction : strobes

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      pins_out <= {1'b0, 3'h7, pins_out.bank, pins_out.addr};
    end
  endtask : idle

  task automatic issue(input dram_cmd_pkg::cmd_t c, input logic [2:0] b,
                       input logic [15:0] a, input logic cke);
    @(posedge clk_sys_in);
    if (c == dram_cmd_pkg::CMD_DESELECT) begin
      // Unselected lines mean nothing, so they never repeat the last value
      pins_out <= {1'b1, ~pins_out.ras_n, ~pins_out.cas_n, ~pins_out.we_n,
                   ~pins_out.bank, ~pins_out.addr};
    end else begin
      pins_out <= {1'b0, strobes(c), b, a};
    end
    cke_out <= cke;
    // Each command stands for one edge; a held command would be taken again
    if (cke !== cke_out) idle(MIN_HOLD);
    else idle(1);
  endtask : issue
endmodule : dram_ctrl_model

// ===== bench/test_dram_cke_and_command_decode.sv
// Self-checking bench for the DRAM command decode block.
// Assumes the controller model drives pins; odt toggles every cycle.
module test_dram_cke_and_command_decode;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int INIT_W = 8;
  localparam int OPER_W = 12;

  logic                     clk_sys_in, resetn_in, cke_in, odt_in;
  logic                     otf_en_in, cfg_chop_in, init_done_in;
  dram_cmd_pkg::cmd_pins_t  pins_in;
  logic [2:0]               pstate_out;
  dram_cmd_pkg::read_info_t read_out;
  logic                     burst_busy_out, cal_busy_out, imp_update_out, act_out;
  logic [7:0]               bank_open_out;
  logic [15:0]              act_row_out, row;
  logic [2:0]               bank;
  int                       failures, compares, cycles, burst_len, cal_len, imp_cnt;
  integer                   seed;
  dram_cmd_pkg::read_info_t exp_rd[$];
  logic [15:0]              exp_row[$];
  int                       exp_len[$], exp_cal[$];

  dram_ctrl_model ctrl (.clk_sys_in(clk_sys_in), .pins_out(pins_in), .cke_out(cke_in));

  dram_cke_and_command_decode #(.INIT_CAL(INIT_W), .OPER_CAL(OPER_W)) DUT (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(1'b1), .cke_in(cke_in),
    .pins_in(pins_in), .odt_in(odt_in), .otf_en_in(otf_en_in),
    .cfg_chop_in(cfg_chop_in), .init_done_in(init_done_in), .pstate_out(pstate_out),
    .read_out(read_out), .burst_busy_out(burst_busy_out), .cal_busy_out(cal_busy_out),
    .imp_update_out(imp_update_out), .bank_open_out(bank_open_out), .act_out(act_out),
    .act_row_out(act_row_out));

  // ********************
  // Checking and reporting
  // ********************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : settle

  // A refused second READ lands inside the first burst
  task automatic do_read(input logic a12, input logic a10);
    logic [15:0] a;
    logic        chop;
    a = $random(seed);
    a[12] = a12;
    a[10] = a10;
    ctrl.issue(dram_cmd_pkg::CMD_READ, bank, a, 1'b1);
    // Burst mode inputs change by non-blocking assignment; read them settled
    chop = otf_en_in ? ~a12 : cfg_chop_in;
    exp_rd.push_back({1'b1, a10, chop, bank, a[2:0]});
    exp_len.push_back(chop ? dram_cmd_pkg::BURST_4_BEATS : dram_cmd_pkg::BURST_8_BEATS);
    ctrl.idle(1);
    ctrl.issue(dram_cmd_pkg::CMD_READ, bank, ~a, 1'b1);
    settle(12);
  endtask : do_read

  task automatic activate();
    row = $random(seed);
    exp_row.push_back(row);
    ctrl.issue(dram_cmd_pkg::CMD_ACTIVATE, bank, row, 1'b1);
    settle(4);
    check(bank_open_out, 8'h01 << bank);
    check(pstate_out, dram_cmd_pkg::ST_ACTIVE);
  endtask : activate

  task automatic cke_step(input dram_cmd_pkg::cmd_t c, input logic cke,
                          input dram_cmd_pkg::pstate_t exp);
    ctrl.issue(c, bank, 16'h0000, cke);
    settle(2);
    check(pstate_out, exp);
  endtask : cke_step

  task automatic do_cal(input logic init_done, input dram_cmd_pkg::cmd_t c, input int win);
    @(posedge clk_sys_in);
    init_done_in <= init_done;
    exp_cal.push_back(win);
    ctrl.issue(c, bank, (c == dram_cmd_pkg::CMD_CAL_LONG) ? 16'h0400 : 16'h0000, 1'b1);
    ctrl.idle(2);
    ctrl.issue(dram_cmd_pkg::CMD_CAL_SHRT, bank, 16'h0000, 1'b1);
    settle(win + 8);
  endtask : do_cal

  // ********************
  // Clock, odt, monitors
  // ********************
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    odt_in <= ~odt_in;
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  always @(posedge clk_sys_in) begin
    #1;
    if (read_out.valid === 1'b1) check(read_out, exp_rd.size() != 0 ? exp_rd.pop_front() : 9'h000);
    if (act_out === 1'b1) check({1'b1, act_row_out}, exp_row.size() != 0 ? {1'b1, exp_row.pop_front()} : 17'h00000);
    if (imp_update_out === 1'b1) imp_cnt++;
    if (burst_busy_out === 1'b1) begin
      burst_len++;
    end else if (burst_len != 0) begin
      check(burst_len, exp_len.size() != 0 ? exp_len.pop_front() : 0);
      burst_len = 0;
    end
    if (cal_busy_out === 1'b1) begin
      cal_len++;
    end else if (cal_len != 0) begin
      check(cal_len, exp_cal.size() != 0 ? exp_cal.pop_front() : 0);
      cal_len = 0;
    end
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    seed = 32'h09b80fef;
    {resetn_in, odt_in, otf_en_in, cfg_chop_in, init_done_in} = 5'h00;
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    settle(1);
    check(pstate_out, dram_cmd_pkg::ST_IDLE);
    check(bank_open_out, 8'h00);
    bank = $random(seed);
    activate();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      otf_en_in   <= i[1];
      cfg_chop_in <= i[0];
      do_read(i[0], 1'b0);
    end
    do_read(1'b1, 1'b1);
    check(bank_open_out, 8'h00);
    activate();
    cke_step(dram_cmd_pkg::CMD_NOP, 1'b0, dram_cmd_pkg::ST_ACT_PDOWN);
    cke_step(dram_cmd_pkg::CMD_READ, 1'b0, dram_cmd_pkg::ST_ACT_PDOWN);
    cke_step(dram_cmd_pkg::CMD_DESELECT, 1'b1, dram_cmd_pkg::ST_ACTIVE);
    ctrl.issue(dram_cmd_pkg::CMD_PRECHG, bank, 16'h0000, 1'b1);
    settle(4);
    check(bank_open_out, 8'h00);
    cke_step(dram_cmd_pkg::CMD_DESELECT, 1'b0, dram_cmd_pkg::ST_PRE_PDOWN);
    cke_step(dram_cmd_pkg::CMD_NOP, 1'b1, dram_cmd_pkg::ST_IDLE);
    cke_step(dram_cmd_pkg::CMD_REFRESH, 1'b0, dram_cmd_pkg::ST_SELF_REF);
    cke_step(dram_cmd_pkg::CMD_ACTIVATE, 1'b0, dram_cmd_pkg::ST_SELF_REF);
    cke_step(dram_cmd_pkg::CMD_DESELECT, 1'b1, dram_cmd_pkg::ST_IDLE);
    do_cal(1'b0, dram_cmd_pkg::CMD_CAL_LONG, INIT_W);
    do_cal(1'b1, dram_cmd_pkg::CMD_CAL_LONG, OPER_W);
    do_cal(1'b1, dram_cmd_pkg::CMD_CAL_SHRT, dram_cmd_pkg::SHORT_CAL_CYC);
    check(imp_cnt, 3);
    check(exp_rd.size() + exp_row.size() + exp_len.size() + exp_cal.size(), 0);
    final_report();
  end
endmodule : test_dram_cke_and_command_decode
